// [verilog/sirb_pkg.sv]
// Package holding register map, field positions and timing of the infrared bank block
package sirb_pkg;
    // Bank-relative register indices (byte address is four times the index)
    localparam logic [2:0] OFS_IDENTITY = 3'h0;
    localparam logic [2:0] OFS_CARRIER = 3'h0;
    localparam logic [2:0] OFS_LCR_SHADOW = 3'h1;
    localparam logic [2:0] OFS_QCR_SHADOW = 3'h2;
    localparam logic [2:0] OFS_IR_SELECT = 3'h2;
    localparam logic [2:0] OFS_PULSE_WIDTH = 3'h2;
    localparam logic [2:0] OFS_BANK_LCR = 3'h3;
    localparam logic [2:0] OFS_BASIC = 3'h4;
    localparam logic [2:0] OFS_TX_LEVEL = 3'h6;
    localparam logic [2:0] OFS_RX_LEVEL = 3'h7;
    // Bank numbers
    localparam logic [2:0] BANK_LEVEL = 3'h2;
    localparam logic [2:0] BANK_IDENT = 3'h3;
    localparam logic [2:0] BANK_SELECT = 3'h4;
    localparam logic [2:0] BANK_BASIC = 3'h5;
    localparam logic [2:0] BANK_PHY = 3'h6;
    // Block-local registers in a word window above the banked window
    localparam logic [7:0] ADDR_EXT_CTRL = 8'h20;
    localparam logic [7:0] ADDR_QCR = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_MASK = 8'h2c;
    localparam logic [7:0] ADDR_MODE = 8'h30;
    // Reset values
    localparam logic [7:0] RST_CARRIER = 8'h20;
    localparam logic [7:0] RST_IR_SELECT = 8'h00;
    localparam logic [7:0] RST_PULSE_WIDTH = 8'h00;
    localparam logic [7:0] RST_BASIC = 8'h02;
    localparam logic [7:0] RST_LCR = 8'h00;
    localparam logic [7:0] RST_QCR = 8'h00;
    localparam logic [7:0] RST_EXT_CTRL = 8'h00;
    // Field positions and masks
    localparam int BIT_FDPLX = 0;
    localparam int BIT_MSSEL = 1;
    localparam int BIT_AUXRX = 4;
    localparam int BIT_MOD_DIS = 6;
    localparam int BIT_DEMOD_DIS = 7;
    localparam int BIT_EXT_SEL = 0;
    localparam int BIT_LOOP = 4;
    localparam logic [7:0] MASK_IR_SELECT = 8'h0c;
    localparam logic [7:0] MASK_BASIC = 8'h13;
    localparam logic [7:0] MASK_CARRIER = 8'he0;
    localparam logic [7:0] MASK_PULSE_WIDTH = 8'h0f;
    localparam logic [7:0] MSR_IR_VALUE = 8'h30;
    localparam logic [3:0] PW_3_16 = 4'h0;
    localparam logic [3:0] PW_FIXED = 4'hd;
    // Status bits
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_RX_FULL = 1;
    localparam int ST_MODEM = 2;
    localparam int ST_WIDTH = 3;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int PULSE_NS = 1600;
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ) / 1000;
    localparam int CARRIER_KHZ = 500;
    localparam int CARRIER_HALF_CYC = (CLK_MHZ * 1000) / (CARRIER_KHZ * 2);

    typedef enum logic [1:0]
    {
        LINK_UART = 2'b00,
        LINK_RSVD = 2'b01,
        LINK_MODIR = 2'b10,
        LINK_SIR = 2'b11
    } sirb_link_t;
endpackage

// [verilog/sirb_top.sv]
// Upper register banks of an infrared serial port, behind an AXI4-Lite slave
// Notes on behaviour
// - Transmit and receive level registers show queue byte counts in bits 4-0.
// - Identity register is read-only: type nibble high, revision nibble low.
// - Line control shadow returns line control value; reading changes nothing.
// - Offset 03h writes of non-bank codes update line control in any bank.
// - Queue control shadow returns queue control contents (also readable at 24h), read-only.
// - Non-extended infrared select picks plain, reserved, modulated or pulse-coded link.
// - Full duplex bit keeps infrared receiver live while transmitting.
// - Infrared mode with modem select set: status reads 30h, interrupt off.
// - Plain serial mode ignores modem select; modem status works normally.
// - Auxiliary select bit takes infrared receive from auxiliary input.
// - Modulation disable bit clear applies 500 KHz carrier to modulated transmit.
// - Demodulation disable bit clear enables 500 KHz receive demodulation in modulated link mode only.
// - Pulse width code 0000 gives 3/16 bit; 1101 gives fixed 1.6 us.
// - Pulse width setting affects only transmit pulses, not the receiver.
// - Extended mode select bit overrides the non-extended infrared select field.
// - Loopback in infrared mode keeps modem interrupts off unless select is 0.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module sirb_top
    import sirb_pkg::*;
#(
    parameter int LEVEL_W = 5,
    parameter logic [3:0] MODULE_TYPE = 4'h5,  // Arbitrary value
    parameter logic [3:0] REVISION = 4'h1      // Arbitrary value
)
(
    // Clock, enable, reset
    input wire logic clk,
    input wire logic clkEn,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Queue levels and modem status from the serial core (same clock)
    input wire logic [LEVEL_W-1:0] txLevel,
    input wire logic [LEVEL_W-1:0] rxLevel,
    input wire logic [7:0] modemStatusRaw,
    input wire logic modemEvent,
    input wire logic txActive,
    input wire logic txBitPulse,
    input wire logic [15:0] bitPeriodCyc,
    // Infrared front end pins
    input wire logic irRxPin,
    input wire logic irRxAuxPin,
    // Controls toward the serial core and transceiver
    output logic [1:0] linkMode,
    output logic [7:0] modemStatusOut,
    output logic modemIntEn,
    output logic irRxOut,
    output logic irTxOut,
    output logic demodEnable,
    output logic [7:0] lineControl,
    output logic [7:0] queueControl,
    output logic irq
);
    if (LEVEL_W < 1 || LEVEL_W > 5)
    begin : gBadLevelW
        $error("LEVEL_W must be 1 to 5");
    end

    // Register state
    logic [7:0] lcr_q, qcr_q, irSel_q, basic_q, carrier_q, pw_q, ext_q;
    logic [2:0] bank_q;
    logic [3:0] stat_q, mask_q;
    logic [1:0] rxSync_q, auxSync_q;
    logic [15:0] pulseCnt_q;
    logic [7:0] carrCnt_q;
    logic carrier_q2;
    logic [LEVEL_W-1:0] txPrev_q, rxPrev_q;

    // Bus handshake state
    logic awHeld_q, wHeld_q, bValid_q, rValid_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q, rData_q;
    logic [3:0] wStrb_q;
    logic [1:0] bResp_q, rResp_q;

    // Decode helpers
    function automatic logic inBank(input logic [7:0] a);
        return a[7:5] == 3'h0 && a[1:0] == 2'b00;
    endfunction

    // Mode decode
    wire extMode = ext_q[BIT_EXT_SEL];
    wire [1:0] irKind = irSel_q[3:2];
    wire [1:0] modeNow = extMode ? LINK_UART : irKind;
    wire irMode = modeNow != LINK_UART;
    wire msForced = irMode && basic_q[BIT_MSSEL];
    wire [7:0] msrView = msForced ? MSR_IR_VALUE : modemStatusRaw;
    wire msIntOk = !msForced;
    wire rxPick = basic_q[BIT_AUXRX] ? auxSync_q[1] : rxSync_q[1];
    wire rxGate = basic_q[BIT_FDPLX] || !txActive;
    wire [15:0] pwTarget = (pw_q[3:0] == PW_FIXED) ? 16'(PULSE_CYC)
        : 16'((32'(bitPeriodCyc) * 3) >> 4);
    wire pulseOn = pulseCnt_q != 16'h0;
    wire modOn = modeNow == LINK_MODIR && !carrier_q[BIT_MOD_DIS];
    wire txDrive = pulseOn && (!modOn || carrier_q2);

    // Write decode
    wire doWrite = awHeld_q && wHeld_q && !bValid_q;
    wire [2:0] wOfs = awAddr_q[4:2];
    wire [7:0] wByte = wData_q[7:0];
    wire wLane = wStrb_q[0];
    wire wBanked = inBank(awAddr_q);
    wire bankCode = wByte[7];
    wire wrLcr = doWrite && wLane && wBanked && wOfs == OFS_BANK_LCR;
    wire wrIrSel = doWrite && wLane && wBanked && bank_q == BANK_SELECT && wOfs == OFS_IR_SELECT;
    wire wrBasic = doWrite && wLane && wBanked && bank_q == BANK_BASIC && wOfs == OFS_BASIC;
    wire wrCarr = doWrite && wLane && wBanked && bank_q == BANK_PHY && wOfs == OFS_CARRIER;
    wire wrPw = doWrite && wLane && wBanked && bank_q == BANK_PHY && wOfs == OFS_PULSE_WIDTH;
    wire wrExt = doWrite && wLane && awAddr_q == ADDR_EXT_CTRL;
    wire wrQcr = doWrite && wLane && awAddr_q == ADDR_QCR;
    wire wrMask = doWrite && wLane && awAddr_q == ADDR_MASK;
    wire wMapped = wBanked || awAddr_q == ADDR_EXT_CTRL || awAddr_q == ADDR_QCR
        || awAddr_q == ADDR_MASK || awAddr_q == ADDR_STATUS || awAddr_q == ADDR_MODE;

    // Read decode
    wire doRead = s_axi_arvalid && !rValid_q;
    wire [2:0] rOfs = s_axi_araddr[4:2];
    wire rBanked = inBank(s_axi_araddr);
    wire [7:0] txLv = 8'(txLevel);
    wire [7:0] rxLv = 8'(rxLevel);
    logic [7:0] bankRead;
    logic bankHit;
    always_comb
    begin
        bankRead = 8'h00;
        bankHit = 1'b1;
        if (rOfs == OFS_BANK_LCR)
            bankRead = lcr_q;
        else if (bank_q == BANK_LEVEL && rOfs == OFS_TX_LEVEL)
            bankRead = txLv;
        else if (bank_q == BANK_LEVEL && rOfs == OFS_RX_LEVEL)
            bankRead = rxLv;
        else if (bank_q == BANK_IDENT && rOfs == OFS_IDENTITY)
            bankRead = {MODULE_TYPE, REVISION};
        else if (bank_q == BANK_IDENT && rOfs == OFS_LCR_SHADOW)
            bankRead = lcr_q;
        else if (bank_q == BANK_IDENT && rOfs == OFS_QCR_SHADOW)
            bankRead = qcr_q;
        else if (bank_q == BANK_SELECT && rOfs == OFS_IR_SELECT)
            bankRead = irSel_q;
        else if (bank_q == BANK_BASIC && rOfs == OFS_BASIC)
            bankRead = basic_q;
        else if (bank_q == BANK_PHY && rOfs == OFS_CARRIER)
            bankRead = carrier_q;
        else if (bank_q == BANK_PHY && rOfs == OFS_PULSE_WIDTH)
            bankRead = pw_q;
        else
            bankHit = 1'b0;
    end
    wire rdStatus = doRead && s_axi_araddr == ADDR_STATUS;
    wire [7:0] rByte = rBanked ? bankRead
        : s_axi_araddr == ADDR_EXT_CTRL ? ext_q
        : s_axi_araddr == ADDR_QCR ? qcr_q
        : s_axi_araddr == ADDR_STATUS ? {4'h0, stat_q}
        : s_axi_araddr == ADDR_MASK ? {4'h0, mask_q}
        : s_axi_araddr == ADDR_MODE ? {6'h0, modeNow} : 8'h00;
    wire rMapped = (rBanked && bankHit) || s_axi_araddr == ADDR_EXT_CTRL
        || s_axi_araddr == ADDR_QCR || s_axi_araddr == ADDR_STATUS
        || s_axi_araddr == ADDR_MASK || s_axi_araddr == ADDR_MODE;

    // Events: transmit queue drained, receive queue reached capacity, modem change
    wire [3:0] evt = {1'b0, modemEvent && msIntOk,
        rxLevel == '1 && rxPrev_q != '1, txLevel == '0 && txPrev_q != '0};
    wire [3:0] statNext = evt | (rdStatus ? 4'h0 : stat_q);

    // Bus handshake
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bValid_q <= 1'b0;
            rValid_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            bResp_q <= 2'b00;
            rResp_q <= 2'b00;
            rData_q <= 32'h0;
        end
        else if (clkEn)
        begin
            if (s_axi_awvalid && !awHeld_q)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld_q)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= wMapped ? 2'b00 : 2'b10;
            end
            else if (bValid_q && s_axi_bready)
                bValid_q <= 1'b0;
            if (doRead)
            begin
                rValid_q <= 1'b1;
                rData_q <= {24'h0, rByte};
                rResp_q <= rMapped ? 2'b00 : 2'b10;
            end
            else if (rValid_q && s_axi_rready)
                rValid_q <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lcr_q <= RST_LCR;
            bank_q <= 3'h0;
            qcr_q <= RST_QCR;
            irSel_q <= RST_IR_SELECT;
            basic_q <= RST_BASIC;
            carrier_q <= RST_CARRIER;
            pw_q <= RST_PULSE_WIDTH;
            ext_q <= RST_EXT_CTRL;
            mask_q <= 4'h0;
            stat_q <= 4'h0;
        end
        else if (clkEn)
        begin
            if (wrLcr && !bankCode)
                lcr_q <= wByte;
            if (wrLcr && bankCode)
                bank_q <= (wByte[6:0] == 7'h0) ? 3'h1 : wByte[6:4] + 3'h2;
            else if (wrLcr)
                bank_q <= 3'h0;
            if (wrIrSel)
                irSel_q <= wByte & MASK_IR_SELECT;
            if (wrBasic)
                basic_q <= wByte & MASK_BASIC;
            if (wrCarr)
                carrier_q <= (wByte & MASK_CARRIER) | RST_CARRIER;
            if (wrPw)
                pw_q <= wByte & MASK_PULSE_WIDTH;
            if (wrExt)
                ext_q <= wByte;
            if (wrQcr)
                qcr_q <= wByte;
            if (wrMask)
                mask_q <= wByte[3:0];
            stat_q <= statNext;
        end
    end

    // Pin synchronisers, pulse shaper and carrier
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxSync_q <= 2'b00;
            auxSync_q <= 2'b00;
            pulseCnt_q <= 16'h0;
            carrCnt_q <= 8'h0;
            carrier_q2 <= 1'b0;
            txPrev_q <= '0;
            rxPrev_q <= '0;
        end
        else if (clkEn)
        begin
            rxSync_q <= {rxSync_q[0], irRxPin};
            auxSync_q <= {auxSync_q[0], irRxAuxPin};
            txPrev_q <= txLevel;
            rxPrev_q <= rxLevel;
            if (txBitPulse)
                pulseCnt_q <= pwTarget;
            else if (pulseOn)
                pulseCnt_q <= pulseCnt_q - 16'h1;
            if (carrCnt_q == 8'(CARRIER_HALF_CYC - 1))
            begin
                carrCnt_q <= 8'h0;
                carrier_q2 <= !carrier_q2;
            end
            else
                carrCnt_q <= carrCnt_q + 8'h1;
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            linkMode <= LINK_UART;
            modemStatusOut <= 8'h00;
            modemIntEn <= 1'b0;
            irRxOut <= 1'b0;
            irTxOut <= 1'b0;
            demodEnable <= 1'b0;
            lineControl <= RST_LCR;
            queueControl <= RST_QCR;
            irq <= 1'b0;
        end
        else if (clkEn)
        begin
            linkMode <= modeNow;
            modemStatusOut <= msrView;
            modemIntEn <= msIntOk;
            irRxOut <= rxPick && rxGate;
            irTxOut <= txDrive;
            demodEnable <= modeNow == LINK_MODIR && !carrier_q[BIT_DEMOD_DIS];
            lineControl <= lcr_q;
            queueControl <= qcr_q;
            irq <= |(stat_q & mask_q);
        end
    end

    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
endmodule

// [tb/sirb_properties.sv]
// Checker of bus and mode relations at the top ports
`timescale 1ns/1ps
module sirb_properties
    import sirb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Mode and control
    input wire logic [7:0] modemStatusRaw,
    input wire logic [1:0] linkMode,
    input wire logic [7:0] modemStatusOut,
    input wire logic modemIntEn,
    input wire logic [7:0] lineControl,
    input wire logic [7:0] queueControl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire logic anyWr = s_axi_awvalid || s_axi_wvalid;
    wire logic plain = linkMode == LINK_UART;

    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_lcr_quiet: assert property (!anyWr && !$past(anyWr) && !$past(anyWr, 2) |=> $stable(lineControl))
        else $error("line control moved without write");
    chk_qcr_quiet: assert property (!anyWr && !$past(anyWr) && !$past(anyWr, 2) |=> $stable(queueControl))
        else $error("queue control moved without write");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_msr_fixed: assert property (!plain && !modemIntEn |-> modemStatusOut == MSR_IR_VALUE)
        else $error("modem status not fixed in infrared mode");
    chk_msr_plain: assert property (plain && $past(plain) && $past(rst_b) |-> modemStatusOut == $past(modemStatusRaw))
        else $error("modem status not raw in plain mode");
    chk_int_plain: assert property (plain && $past(plain) && $past(rst_b) |-> modemIntEn)
        else $error("modem interrupt off in plain mode");
endmodule

bind sirb_top sirb_properties u_chk (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .modemStatusRaw(modemStatusRaw), .linkMode(linkMode), .modemStatusOut(modemStatusOut),
    .modemIntEn(modemIntEn), .lineControl(lineControl), .queueControl(queueControl));

// [tb/sirb_front_model.sv]
// Infrared front end model: drives receive pins, times transmit pulses
`timescale 1ns/1ps
module sirb_front_model
(
    // Clock
    input wire logic clk,
    // Levels asked for by the bench
    input wire logic mainLevel,
    input wire logic auxLevel,
    // Transceiver pins
    input wire logic irTxOut,
    output logic irRxPin,
    output logic irRxAuxPin,
    // Length in clocks of the last transmit pulse
    output logic [15:0] pulseLen
);
    logic [15:0] run = 16'h0;
    initial pulseLen = 16'h0;
    assign irRxPin = mainLevel;
    assign irRxAuxPin = auxLevel;
    always @(posedge clk)
    begin
        if (irTxOut)
            run <= run + 16'h1;
        else if (run != 16'h0)
        begin
            pulseLen <= run;
            run <= 16'h0;
        end
    end
endmodule

// [tb/serial_ir_bank_registers_bench.sv]
// Self-checking bench of the infrared bank block
`timescale 1ns/1ps
module serial_ir_bank_registers_bench
    import sirb_pkg::*;
;
    localparam logic [7:0] IDENT = 8'h73; // Arbitrary identity value
    logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, raw = 0;
    logic [31:0] wdata = 0, rdata, rv;
    logic awready, wready, bvalid, arready, rvalid, irRxPin, irRxAuxPin, irTxOut;
    logic [1:0] bresp, rresp, linkMode;
    logic [4:0] txLevel = 0, rxLevel = 0;
    logic modemEvent = 0, txActive = 0, txBitPulse = 0, mainL = 0, auxL = 0;
    logic [15:0] bitPeriodCyc = 16'd64, pulseLen;
    logic [7:0] modemStatusOut, lineControl, queueControl;
    logic modemIntEn, irRxOut, demodEnable, irq;
    int num_errors = 0, checks = 0, cyc = 0;

    always #4 clk = ~clk;
    sirb_top #(.LEVEL_W(5), .MODULE_TYPE(4'h7), .REVISION(4'h3)) DUT (.clk(clk), .clkEn(1'b1),
        .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .txLevel(txLevel), .rxLevel(rxLevel), .modemStatusRaw(raw), .modemEvent(modemEvent),
        .txActive(txActive), .txBitPulse(txBitPulse), .bitPeriodCyc(bitPeriodCyc),
        .irRxPin(irRxPin), .irRxAuxPin(irRxAuxPin), .linkMode(linkMode),
        .modemStatusOut(modemStatusOut), .modemIntEn(modemIntEn), .irRxOut(irRxOut),
        .irTxOut(irTxOut), .demodEnable(demodEnable), .lineControl(lineControl),
        .queueControl(queueControl), .irq(irq));
    sirb_front_model u_front (.clk(clk), .mainLevel(mainL), .auxLevel(auxL),
        .irTxOut(irTxOut), .irRxPin(irRxPin), .irRxAuxPin(irRxAuxPin), .pulseLen(pulseLen));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("ERROR %0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic busy;
        busy = 1;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (busy)
        begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) busy = 0;
        end
        bready <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        logic busy;
        busy = 1;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (busy)
        begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            if (rvalid)
            begin
                rv = rdata;
                busy = 0;
            end
        end
        rready <= 0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
        rd(a);
        chk(rv[15:0], 16'(e), m);
    endtask
    task automatic bank(input int b);
        wr(8'h0c, b == 1 ? 8'h80 : 8'h81 | 8'((b - 2) << 4));
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic lvl(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v1, v2;
        rd(a);
        v1 = rv;
        rd(a);
        v2 = rv;
        rd(a);
        chk(v1 == v2 ? v2[15:0] : rv[15:0], 16'(e), "queue level");
    endtask

    task automatic t_reset();
        rd(8'h40);
        chk(16'(rresp), 16'h2, "unmapped response");
        bank(6);
        rchk(8'h00, RST_CARRIER, "carrier reset");
        rchk(8'h08, 8'h00, "pulse width reset");
        bank(4);
        rchk(8'h08, 8'h00, "ir select reset");
        bank(5);
        rchk(8'h10, 8'h02, "basic reset");
        bank(3);
        rchk(8'h00, IDENT, "identity");
        wr(8'h00, 8'hff);
        rchk(8'h00, IDENT, "identity after write");
    endtask
    task automatic t_levels();
        txLevel <= 5'h1f;
        rxLevel <= 5'h0a;
        bank(2);
        lvl(8'h18, 8'h1f);
        lvl(8'h1c, 8'h0a);
    endtask
    task automatic t_shadow();
        wr(8'h0c, 8'h1b);
        chk(16'(lineControl), 16'h1b, "line control write");
        bank(3);
        chk(16'(lineControl), 16'h1b, "bank code kept line control");
        rchk(8'h04, 8'h1b, "line shadow");
        chk(16'(lineControl), 16'h1b, "shadow read side effect");
        wr(8'h24, 8'hc7);
        wr(8'h08, 8'h00);
        rchk(8'h08, 8'hc7, "queue shadow");
        chk(16'(queueControl), 16'hc7, "queue control");
        bank(5);
        wr(8'h0c, 8'h03);
        chk(16'(lineControl), 16'h03, "line control from bank 5");
    endtask
    task automatic t_modes();
        raw <= 8'h5a;
        bank(4);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h08, 8'(k << 2));
            wait_n(2);
            chk(16'(linkMode), 16'(k), "link mode");
            chk(16'(modemStatusOut), k == 0 ? 16'h5a : 16'h30, "modem status");
            chk(16'(modemIntEn), 16'(k == 0), "modem interrupt enable");
        end
        wr(8'h20, 8'h01);
        wait_n(2);
        chk(16'(linkMode), 16'h0, "extended overrides");
        wr(8'h20, 8'h00);
        bank(5);
        wr(8'h10, 8'h00);
        wait_n(2);
        chk(16'(modemStatusOut), 16'h5a, "select 0 raw status");
        chk(16'(modemIntEn), 16'h1, "select 0 interrupt");
    endtask
    task automatic t_irq();
        wr(8'h2c, 8'h04);
        rd(8'h28);
        modemEvent <= 1;
        @(posedge clk) modemEvent <= 0;
        wait_n(2);
        chk(16'(irq), 16'h1, "modem interrupt raised");
        rchk(8'h28, 8'h04, "status sticky");
        chk(16'(irq), 16'h0, "read clears");
        wr(8'h2c, 8'h00);
        modemEvent <= 1;
        @(posedge clk) modemEvent <= 0;
        wait_n(2);
        chk(16'(irq), 16'h0, "masked interrupt");
        rd(8'h28);
        chk(16'(rv[2]), 16'h1, "masked status set");
        wr(8'h2c, 8'h04);
        wr(8'h10, 8'h02);
        wr(8'h20, 8'h10);
        modemEvent <= 1;
        @(posedge clk) modemEvent <= 0;
        wait_n(2);
        chk(16'(irq), 16'h0, "loopback modem interrupt");
        rd(8'h28);
        chk(16'(rv[2]), 16'h0, "loopback modem status");
        wr(8'h10, 8'h00);
        modemEvent <= 1;
        @(posedge clk) modemEvent <= 0;
        wait_n(2);
        chk(16'(irq), 16'h1, "loopback select 0 interrupt");
        wr(8'h20, 8'h00);
    endtask
    task automatic t_rx();
        mainL <= 1;
        wait_n(5);
        chk(16'(irRxOut), 16'h1, "main input");
        wr(8'h10, 8'h12);
        wait_n(5);
        chk(16'(irRxOut), 16'h0, "aux input low");
        auxL <= 1;
        mainL <= 0;
        wait_n(5);
        chk(16'(irRxOut), 16'h1, "aux input high");
        txActive <= 1;
        wait_n(5);
        chk(16'(irRxOut), 16'h0, "masked while sending");
        wr(8'h10, 8'h13);
        wait_n(5);
        chk(16'(irRxOut), 16'h1, "full duplex");
        txActive <= 0;
    endtask
    task automatic t_pulse();
        bank(6);
        wr(8'h08, {4'h0, PW_FIXED});
        txBitPulse <= 1;
        @(posedge clk) txBitPulse <= 0;
        wait_n(PULSE_CYC + 20);
        chk(pulseLen, 16'(PULSE_CYC), "fixed pulse");
        wr(8'h08, {4'h0, PW_3_16});
        txBitPulse <= 1;
        @(posedge clk) txBitPulse <= 0;
        wait_n(40);
        chk(pulseLen, (bitPeriodCyc * 3) >> 4, "3/16 pulse");
        chk(16'(irRxOut), 16'h1, "receiver untouched");
        bank(4);
        wr(8'h08, 8'h08);
        bank(6);
        wr(8'h00, 8'h80);
        wait_n(2);
        chk(16'(demodEnable), 16'h0, "demodulation off");
        wr(8'h00, 8'h00);
        wait_n(2);
        chk(16'(demodEnable), 16'h1, "demodulation on");
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        t_reset();
        t_levels();
        t_shadow();
        t_modes();
        t_irq();
        t_rx();
        t_pulse();
        report_and_stop();
    end
endmodule
